//--- logic/fsq_pkg.sv
// Constants, types and helpers shared by the full status query responder.
package fsq_pkg;

  // ------------------------------------------------------------------
  // Frame identifiers and fixed byte values
  // ------------------------------------------------------------------
  localparam logic [7:0] ID_LONG_PREP  = 8'h3C; // Fixed preparing identifier.
  localparam logic [7:0] ID_READ       = 8'h7D; // Fixed reading identifier.
  localparam logic [7:0] APP_CMD_BYTE  = 8'h80; // Application command byte.
  localparam logic [6:0] CMD_FULL_STAT = 7'h01; // Query command code.
  localparam logic [7:0] FILLER_BYTE   = 8'hFF; // Filler and do-not-care.
  localparam logic [4:0] SEC_POS_PAD   = 5'h1F; // Ones above safe pos top.

  // ------------------------------------------------------------------
  // Byte positions within frames
  // ------------------------------------------------------------------
  localparam logic [3:0] POS_FIRST     = 4'h1; // First data byte.
  localparam logic [3:0] POS_SECOND    = 4'h2; // Second data byte.
  localparam logic [3:0] POS_THIRD     = 4'h3; // Third data byte.
  localparam logic [3:0] SHORT_LAST    = 4'h2; // Last byte, short frame.
  localparam logic [3:0] LONG_LAST     = 4'h8; // Last byte, long frame.
  localparam logic [3:0] RESP_LAST     = 4'h8; // Last answered byte.

  // ------------------------------------------------------------------
  // Reading stages and fault flag layout
  // ------------------------------------------------------------------
  localparam logic [1:0] STAGE_NONE    = 2'h0; // Nothing prepared.
  localparam logic [1:0] STAGE_FIRST   = 2'h1; // First reading frame due.
  localparam logic [1:0] STAGE_SECOND  = 2'h2; // Second reading frame due.

  localparam int         FLAG_COUNT    = 9;    // Number of latched faults.
  localparam int         FLG_TW        = 0;    // Thermal warning.
  localparam int         FLG_TSD       = 1;    // Thermal shutdown.
  localparam int         FLG_UV        = 2;    // Undervoltage.
  localparam int         FLG_ELDEF     = 3;    // Electrical defect.
  localparam int         FLG_MISSED_STEP_FLAG  = 4;    // Missed step.
  localparam int         FLG_CHARGE_PUMP_FAILURE    = 5;    // Charge pump failure.
  localparam int         FLG_OVC_A     = 6;    // Coil A overcurrent.
  localparam int         FLG_OVC_B     = 7;    // Coil B overcurrent.
  localparam int         FLG_SUPPLY    = 8;    // Logic supply reset.
  localparam logic [8:0] FLAG_RESET    = 9'h100; // Supply flag set at reset.

  // ------------------------------------------------------------------
  // Frame tracking states
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_HDR   = 5'b00010,
    ST_SHORT = 5'b00100,
    ST_LONG  = 5'b01000,
    ST_READ  = 5'b10000
  } frame_state_t;

  // Builds a protected identifier byte with both parity bits on top.
  function automatic logic [7:0] lin_protect(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    lin_protect = {p1, p0, id};
  endfunction

endpackage

//--- logic/fault_flag_latch.sv
// Sticky fault flags that survive a clear while their condition stays.
`timescale 1ns/10ps

module fault_flag_latch #(
  parameter int                 WIDTH       = 9,     // Number of flags.
  parameter logic [WIDTH-1:0]   RESET_VALUE = '0     // Flags after reset.
) (
  input  wire logic             core_clk,  // Core clock.
  input  wire logic             rst,       // Synchronous reset, high.
  input  wire logic [WIDTH-1:0] set_cond,  // Fault conditions, level.
  input  wire logic             clear_req, // Clear attempt, one pulse.
  output logic      [WIDTH-1:0] flags      // Latched fault flags.
);

  logic [WIDTH-1:0] next_flags;

  // A present condition always wins over a clear attempt.
  assign next_flags = set_cond | (clear_req ? '0 : flags); // [RL17]

  // Flag storage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags <= RESET_VALUE;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

//--- logic/full_status_query_responder.sv
// Slave handler that answers the full status query over LIN frames.
`timescale 1ns/10ps

// Behaviour
// RL1 - Short preparing frame: protected id, command 0x81, 1 plus address.
// RL2 - Long preparing frame: id 0x3C, 0x80, command, address, five 0xFF.
// RL3 - Master opens a query with exactly one preparing frame, either form.
// RL4 - Short frame id is the dynamic five-bit id with bit 5 cleared.
// RL5 - Identifier top two bits carry standard LIN parity of lower bits.
// RL6 - Reading frames use id 0x7D; byte 1 answers 1 plus node address.
// RL7 - Missing second reading frame is tolerated without any error.
// RL8 - Frame one byte 2: run current high nibble, hold current low.
// RL9 - Frame one byte 3: maximum velocity high nibble, minimum low.
// RL10 - Frame one byte 4: profile, step resolution, direction, acceleration.
// RL11 - Frame one byte 5: six fault flags then two-bit temperature level.
// RL12 - Frame one byte 6: motion, switch, coil faults, one, charge pump.
// RL13 - Frame one byte 7 link error status, byte 8 is 0xFF.
// RL14 - Frame two: current, goal positions high first, safe position, 0xFF.
// RL15 - After reporting, attempt to clear all nine latched fault flags.
// RL16 - Wrong address in preparing frame: ignore and stay silent afterwards.
// RL17 - A flag whose condition persists stays set through the clear.
module full_status_query_responder
  import fsq_pkg::*;
(
  input  wire logic        core_clk,            // Core clock, 25 MHz.
  input  wire logic        rst,                 // Synchronous reset, high.
  input  wire logic        frame_start,         // Header break seen, pulse.
  input  wire logic        rx_valid,            // Received byte strobe.
  input  wire logic [7:0]  rx_byte,             // Received byte.
  input  wire logic        tx_done,             // Answer byte sent, pulse.
  input  wire logic [4:0]  prep_id,             // Dynamic preparing id.
  input  wire logic [6:0]  node_address,        // Own node address.
  input  wire logic [3:0]  run_current,         // Run current setting.
  input  wire logic [3:0]  hold_current,        // Hold current setting.
  input  wire logic [3:0]  max_velocity,        // Maximum velocity.
  input  wire logic [3:0]  min_velocity,        // Minimum velocity.
  input  wire logic        acceleration_profile_select, // Ramp shape.
  input  wire logic [1:0]  microstep_resolution, // Step mode.
  input  wire logic        rotation_direction,  // Shaft direction.
  input  wire logic [3:0]  acceleration,        // Acceleration setting.
  input  wire logic [1:0]  temperature_level,   // Temperature info.
  input  wire logic [2:0]  motion_state,        // Motion state.
  input  wire logic        external_switch_state, // Switch input level.
  input  wire logic [7:0]  lin_error_status,    // Link error status.
  input  wire logic [15:0] current_position,    // Actual position.
  input  wire logic [15:0] goal_position,       // Target position.
  input  wire logic [10:0] safe_position,       // Secure position.
  input  wire logic        tw_cond,             // Thermal warning now.
  input  wire logic        tsd_cond,            // Thermal shutdown now.
  input  wire logic        uv_cond,             // Undervoltage now.
  input  wire logic        eldef_cond,          // Electrical defect now.
  input  wire logic        missed_step_flag_cond,       // Missed step event.
  input  wire logic        charge_pump_failure_cond,         // Charge pump failing now.
  input  wire logic        ovc_a_cond,          // Coil A overcurrent now.
  input  wire logic        ovc_b_cond,          // Coil B overcurrent now.
  input  wire logic        supply_cond,         // Logic supply reset event.
  output logic             resp_active,         // Node answers this frame.
  output logic      [7:0]  tx_byte,             // Byte to send next.
  output logic             thermal_warning,     // Latched flag.
  output logic             thermal_shutdown,    // Latched flag.
  output logic             undervoltage_flag,   // Latched flag.
  output logic             electrical_defect_flag, // Latched flag.
  output logic             missed_step_flag,    // Latched flag.
  output logic             charge_pump_failure, // Latched flag.
  output logic             coil_a_overcurrent,  // Latched flag.
  output logic             coil_b_overcurrent,  // Latched flag.
  output logic             logic_supply_reset_flag // Latched flag.
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  frame_state_t            state;
  frame_state_t            next_state;
  logic [3:0]              byte_pos;
  logic [3:0]              next_pos;
  logic                    prep_ok;
  logic                    next_ok;
  logic [1:0]              stage;
  logic [1:0]              next_stage;
  logic [1:0]              serve;
  logic [1:0]              next_serve;
  logic [3:0]              idx;
  logic [3:0]              next_idx;
  logic                    next_active;
  logic [7:0]              next_tx;
  logic                    clear_req;
  logic                    next_clear;
  logic [FLAG_COUNT-1:0]   flags;
  logic [FLAG_COUNT-1:0]   conds;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Expected byte of a preparing frame at a given data position.
  function automatic logic [7:0] expect_byte(input logic       is_long,
                                             input logic [3:0] pos,
                                             input logic [7:0] addr);
    if (!is_long) begin
      expect_byte = (pos == POS_FIRST) ? {1'b1, CMD_FULL_STAT} : addr;
    end else begin
      case (pos)
        POS_FIRST:  expect_byte = APP_CMD_BYTE;
        POS_SECOND: expect_byte = {1'b1, CMD_FULL_STAT};
        POS_THIRD:  expect_byte = addr;
        default:    expect_byte = FILLER_BYTE;
      endcase
    end
  endfunction

  // Picks answer byte n (1 to 8) from a packed eight-byte frame word.
  function automatic logic [7:0] pick_byte(input logic [63:0] w,
                                           input logic [3:0]  n);
    case (n)
      4'h1:    pick_byte = w[63:56];
      4'h2:    pick_byte = w[55:48];
      4'h3:    pick_byte = w[47:40];
      4'h4:    pick_byte = w[39:32];
      4'h5:    pick_byte = w[31:24];
      4'h6:    pick_byte = w[23:16];
      4'h7:    pick_byte = w[15:8];
      default: pick_byte = w[7:0];
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Fault flags
  // ------------------------------------------------------------------
  // Conditions gathered into the flag layout.
  assign conds = {supply_cond, ovc_b_cond, ovc_a_cond, charge_pump_failure_cond,
                  missed_step_flag_cond, eldef_cond, uv_cond, tsd_cond, tw_cond};

  fault_flag_latch #(.WIDTH(FLAG_COUNT), .RESET_VALUE(FLAG_RESET)) u_flags (
    .core_clk  (core_clk),
    .rst       (rst),
    .set_cond  (conds),
    .clear_req (clear_req),
    .flags     (flags)
  );

  // Flag outputs come straight from the latch registers.
  assign thermal_warning         = flags[FLG_TW];
  assign thermal_shutdown        = flags[FLG_TSD];
  assign undervoltage_flag       = flags[FLG_UV];
  assign electrical_defect_flag  = flags[FLG_ELDEF];
  assign missed_step_flag        = flags[FLG_MISSED_STEP_FLAG];
  assign charge_pump_failure     = flags[FLG_CHARGE_PUMP_FAILURE];
  assign coil_a_overcurrent      = flags[FLG_OVC_A];
  assign coil_b_overcurrent      = flags[FLG_OVC_B];
  assign logic_supply_reset_flag = flags[FLG_SUPPLY];

  // ------------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------------
  logic [3:0]  data_pos;
  logic [7:0]  addr_byte;
  logic        is_read_id;
  logic        is_long_id;
  logic        is_short_id;
  logic        byte_match;
  logic        last_prep;
  logic [63:0] frame1_word;
  logic [63:0] frame2_word;
  logic [63:0] start_word;
  logic [63:0] serve_word;

  // Identifier and preparing byte checks; the dynamic id has bit 5 clear.
  assign data_pos    = byte_pos + 4'h1;
  assign addr_byte   = {1'b1, node_address};                     // [RL6]
  assign is_read_id  = (rx_byte == ID_READ);                     // [RL6]
  assign is_long_id  = (rx_byte == ID_LONG_PREP);                // [RL2]
  assign is_short_id = (rx_byte == lin_protect({1'b0, prep_id})); // [RL4][RL5]
  assign byte_match  = (rx_byte == expect_byte(state == ST_LONG,
                                               data_pos, addr_byte)); // [RL1]
  assign last_prep   = ((state == ST_SHORT) && (data_pos == SHORT_LAST)) ||
                       ((state == ST_LONG) && (data_pos == LONG_LAST));

  // First reading frame: settings, fault flags and link errors.
  assign frame1_word = {addr_byte,
                        run_current, hold_current,               // [RL8]
                        max_velocity, min_velocity,              // [RL9]
                        acceleration_profile_select,
                        microstep_resolution,
                        rotation_direction, acceleration,        // [RL10]
                        flags[FLG_SUPPLY], flags[FLG_MISSED_STEP_FLAG],
                        flags[FLG_ELDEF], flags[FLG_UV],
                        flags[FLG_TSD], flags[FLG_TW],
                        temperature_level,                       // [RL11]
                        motion_state, external_switch_state,
                        flags[FLG_OVC_A], flags[FLG_OVC_B], 1'b1,
                        flags[FLG_CHARGE_PUMP_FAILURE],                       // [RL12]
                        lin_error_status, FILLER_BYTE};          // [RL13]

  // Second reading frame: current and goal positions high byte first, safe position low byte first.
  assign frame2_word = {addr_byte, current_position, goal_position,
                        safe_position[7:0], SEC_POS_PAD,
                        safe_position[10:8], FILLER_BYTE};       // [RL14]
  // Word for a reading frame that opens, and for the one being served.
  assign start_word  = (stage == STAGE_SECOND) ? frame2_word : frame1_word;
  assign serve_word  = (serve == STAGE_SECOND) ? frame2_word : frame1_word;

  // ------------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------------
  // Next state; any header other than a reading one drops a prepared query.
  always_comb begin
    next_state  = state;
    next_pos    = byte_pos;
    next_ok     = prep_ok;
    next_stage  = stage;
    next_serve  = serve;
    next_idx    = idx;
    next_active = resp_active;
    next_tx     = tx_byte;
    next_clear  = 1'b0;
    if (frame_start) begin
      next_state  = ST_HDR;
      next_pos    = 4'h0;
      next_active = 1'b0;
    end else begin
      case (state)
        ST_HDR: begin
          if (rx_valid) begin
            next_ok  = 1'b1;
            if (is_read_id && (stage != STAGE_NONE)) begin // [RL16]
              next_state  = ST_READ;                             // [RL6]
              next_active = 1'b1;
              next_serve  = stage;
              next_idx    = POS_FIRST;
              next_tx     = pick_byte(start_word, POS_FIRST);
            end else if (is_long_id) begin
              next_state = ST_LONG;                              // [RL3]
              next_stage = STAGE_NONE;
            end else if (is_short_id) begin
              next_state = ST_SHORT;                             // [RL3]
              next_stage = STAGE_NONE;
            end else begin
              next_state = ST_IDLE;
              next_stage = STAGE_NONE;
            end
          end
        end
        ST_SHORT, ST_LONG: begin
          if (rx_valid) begin
            next_pos = data_pos;
            next_ok  = prep_ok && byte_match;
            if (last_prep) begin
              next_state = ST_IDLE;
              next_stage = next_ok ? STAGE_FIRST : STAGE_NONE; // [RL16]
            end
          end
        end
        ST_READ: begin
          if (tx_done) begin
            if (idx == RESP_LAST) begin
              next_active = 1'b0;
              next_state  = ST_IDLE;
              next_stage  = (serve == STAGE_FIRST) ? STAGE_SECOND
                                                   : STAGE_NONE; // [RL7]
              next_clear  = (serve == STAGE_FIRST);              // [RL15]
            end else begin
              next_idx = idx + 4'h1;
              next_tx  = pick_byte(serve_word, idx + 4'h1);
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Tracking registers.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state       <= ST_IDLE;
      byte_pos    <= 4'h0;
      prep_ok     <= 1'b0;
      stage       <= STAGE_NONE;
      serve       <= STAGE_NONE;
      idx         <= 4'h0;
      resp_active <= 1'b0;
      tx_byte     <= FILLER_BYTE;
      clear_req   <= 1'b0;
    end else begin
      state       <= next_state;
      byte_pos    <= next_pos;
      prep_ok     <= next_ok;
      stage       <= next_stage;
      serve       <= next_serve;
      idx         <= next_idx;
      resp_active <= next_active;
      tx_byte     <= next_tx;
      clear_req   <= next_clear;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  resp_start_a: assert property ( // [RL6]
    !frame_start && rx_valid && (state == ST_HDR) && is_read_id &&
    (stage == STAGE_FIRST) |=> resp_active && (tx_byte == addr_byte))
    else $error("Reading frame not answered with node address.");
  stay_silent_a: assert property ( // [RL16]
    !frame_start && rx_valid && (state == ST_HDR) && is_read_id &&
    (stage == STAGE_NONE) |=> !resp_active)
    else $error("Answered a reading frame without preparation.");
  short_arm_a: assert property ( // [RL1]
    !frame_start && rx_valid && (state == ST_SHORT) && (byte_pos == 4'h1) &&
    prep_ok && (rx_byte == addr_byte) |=> (stage == STAGE_FIRST))
    else $error("Valid short preparing frame did not arm.");
  long_arm_a: assert property ( // [RL2]
    !frame_start && rx_valid && (state == ST_LONG) && (byte_pos == 4'h7) &&
    prep_ok && (rx_byte == FILLER_BYTE) |=> (stage == STAGE_FIRST))
    else $error("Valid long preparing frame did not arm.");
  addr_reject_a: assert property ( // [RL16]
    !frame_start && rx_valid && (state == ST_SHORT) && (byte_pos == 4'h1) &&
    (rx_byte != addr_byte) |=> (stage == STAGE_NONE))
    else $error("Foreign address armed the query.");
  frame_end_a: assert property ( // [RL15]
    !frame_start && (state == ST_READ) && tx_done && (idx == RESP_LAST) &&
    (serve == STAGE_FIRST) |=> clear_req && (stage == STAGE_SECOND) &&
    !resp_active ##1 !clear_req)
    else $error("First frame end did not clear flags once.");
  flag_hold_a: assert property ( // [RL17]
    clear_req |=> (flags == $past(conds)))
    else $error("Clear did not leave exactly the present faults.");
  filler_last_a: assert property ( // [RL13]
    resp_active && (idx == RESP_LAST) |-> (tx_byte == FILLER_BYTE))
    else $error("Last answer byte is not filler.");
  current_byte_a: assert property ( // [RL8]
    !frame_start && (state == ST_READ) && tx_done && (idx == POS_FIRST) &&
    (serve == STAGE_FIRST) |=> (tx_byte == $past({run_current,
                                                  hold_current})))
    else $error("Current settings byte is wrong.");

endmodule

//--- tb/lin_master_model.sv
// LIN master model that frames bytes and collects answers.
`timescale 1ns/10ps
module lin_master_model (
  input  wire logic       core_clk,    // Core clock.
  input  wire logic       resp_active, // Node answers.
  input  wire logic [7:0] tx_byte,     // Answer byte.
  output logic            frame_start, // Header pulse.
  output logic            rx_valid,    // Byte strobe.
  output logic      [7:0] rx_byte,     // Bus byte.
  output logic            tx_done      // Answer byte sent.
);
  logic [7:0] got [1:8]; // Bytes answered in the last frame.
  int         n_got;     // Count of answered bytes.

  // Bus is idle at time zero.
  initial {frame_start, rx_valid, rx_byte, tx_done} = 11'h000;

  // Protected identifier with both parity bits on top.
  function automatic logic [7:0] protect(input logic [5:0] i);
    return {~^{i[1], i[3], i[4], i[5]}, ^{i[0], i[1], i[2], i[4]}, i};
  endfunction

  // One byte; the released line shows the inverse afterwards.
  task automatic put(input logic [7:0] b);
    @(posedge core_clk) {rx_valid, rx_byte} <= {1'b1, b};
    @(posedge core_clk) {rx_valid, rx_byte} <= {1'b0, ~b};
  endtask

  // Header break followed by the identifier byte.
  task automatic header(input logic [7:0] id);
    @(posedge core_clk) frame_start <= 1'b1;
    @(posedge core_clk) frame_start <= 1'b0;
    put(id);
  endtask

  // Short preparing frame on the dynamic identifier.
  task automatic prep_short(input logic [4:0] id, input logic [6:0] a);
    header(protect({1'b0, id}));
    put(8'h81);
    put({1'b1, a});
  endtask

  // Long preparing frame on the fixed identifier.
  task automatic prep_long(input logic [6:0] a);
    header(8'h3C);
    put(8'h80);
    put(8'h81);
    put({1'b1, a});
    repeat (5) put(8'hFF);
  endtask

  // Reading frame: takes up to eight answered bytes.
  task automatic read_frame();
    n_got = 0;
    header(8'h7D);
    for (int i = 1; i <= 8; i++) begin
      @(posedge core_clk);
      @(negedge core_clk);
      got[i] = resp_active ? tx_byte : 8'h00;
      if (resp_active) begin
        n_got++;
        @(posedge core_clk) tx_done <= 1'b1;
        @(posedge core_clk) tx_done <= 1'b0;
      end
    end
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the full status query responder.
`timescale 1ns/10ps
module tb;
  import fsq_pkg::*;
  logic        core_clk = 1'b0, rst = 1'b1;
  logic        frame_start, rx_valid, tx_done, resp_active;
  logic [7:0]  rx_byte, tx_byte;
  logic [4:0]  prep_id = 5'h0A;
  logic [6:0]  node_address = 7'h15;
  logic [3:0]  run_current = 4'hA, hold_current = 4'h3, acceleration = 4'h5;
  logic [3:0]  max_velocity = 4'hC, min_velocity = 4'h2;
  logic        acceleration_profile_select = 1'b1, rotation_direction = 1'b0;
  logic [1:0]  microstep_resolution = 2'h2, temperature_level = 2'h1;
  logic [2:0]  motion_state = 3'h5;
  logic        external_switch_state = 1'b1;
  logic [7:0]  lin_error_status = 8'h5A;
  logic [15:0] current_position = 16'h1234, goal_position = 16'hABCD;
  logic [10:0] safe_position = 11'h5E7;
  logic [8:0]  cond = 9'h000;
  logic [8:0]  flg;
  int          error_cnt = 0, cmp_count = 0;

  full_status_query_responder dut_u (
    .tw_cond(cond[0]), .tsd_cond(cond[1]), .uv_cond(cond[2]),
    .eldef_cond(cond[3]), .missed_step_flag_cond(cond[4]), .charge_pump_failure_cond(cond[5]),
    .ovc_a_cond(cond[6]), .ovc_b_cond(cond[7]), .supply_cond(cond[8]),
    .thermal_warning(flg[0]), .thermal_shutdown(flg[1]),
    .undervoltage_flag(flg[2]), .electrical_defect_flag(flg[3]),
    .missed_step_flag(flg[4]), .charge_pump_failure(flg[5]),
    .coil_a_overcurrent(flg[6]), .coil_b_overcurrent(flg[7]),
    .logic_supply_reset_flag(flg[8]), .*);
  lin_master_model m_u (.*);

  // ------------------------------------------------------------------
  // Checks and closing
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_frame(input logic [7:0] e [1:8]);
    for (int i = 1; i <= 8; i++)
      chk($sformatf("byte %0d", i), {8'h00, e[i]}, {8'h00, m_u.got[i]});
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Clock at 25 MHz.
  always #20 core_clk = ~core_clk;

  // Watchdog: tests need well under a thousand cycles.
  initial begin
    #400000;
    error_cnt++;
    end_sim();
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk) cond <= 9'h1FF;
    @(posedge core_clk) cond <= 9'h002;
    m_u.prep_short(prep_id, node_address);
    m_u.read_frame();
    chk_frame('{8'h95, 8'hA3, 8'hC2, 8'hC5,
                8'hFD, 8'hBF, 8'h5A, 8'hFF});
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("fault flags", 16'h0002, {7'h00, flg});
    m_u.read_frame();
    chk_frame('{8'h95, 8'h12, 8'h34, 8'hAB,
                8'hCD, 8'hE7, 8'hFD, 8'hFF});
    $display("test 1 done");
    m_u.prep_long(node_address);
    m_u.read_frame();
    chk_frame('{8'h95, 8'hA3, 8'hC2, 8'hC5,
                8'h09, 8'hB2, 8'h5A, 8'hFF});
    m_u.prep_short(prep_id, 7'h16);
    m_u.read_frame();
    chk("answered bytes", 16'h0000, m_u.n_got[15:0]);
    $display("test 2 done");
    m_u.prep_long(node_address);
    m_u.read_frame();
    chk("answered bytes", 16'h0008, m_u.n_got[15:0]);
    chk_frame('{8'h95, 8'hA3, 8'hC2, 8'hC5,
                8'h09, 8'hB2, 8'h5A, 8'hFF});
    $display("test 3 done");
    end_sim();
  end
endmodule
